// ===== gtp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= inc(wr_q);
      end
      if (pop) begin
        rd_q <= inc(rd_q);
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== gtp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// host processor and dma controller
// ************************************************
module gtp_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] hdata_out,
  input  wire logic       hdata_oe,
  output logic      [7:0] hdata_in,
  output logic            chip_en_n,
  output logic            read_direction,
  output logic            write_n,
  output logic      [2:0] reg_select,
  output logic            dma_grant_n
);
  logic [7:0] drv_q;
  logic       drv_en;

  // released bus floats to the pin pull-ups
  assign hdata_in = hdata_oe ? hdata_out : (drv_en ? drv_q : 8'hFF);

  initial begin
    drv_q          = 8'h00;
    drv_en         = 1'b0;
    chip_en_n      = 1'b1;
    read_direction = 1'b0;
    write_n        = 1'b1;
    reg_select     = 3'h0;
    dma_grant_n    = 1'b1;
  end

  // strobes held 6 cycles, 6 idle after: covers the 3 cycle pin lag
  task automatic acc(input logic ce_n, input logic dma, input logic wr,
                     input logic [2:0] rs, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    chip_en_n      = ce_n | dma;
    dma_grant_n    = !dma;
    read_direction = dma ? wr : !wr;
    reg_select     = rs;
    drv_q          = d;
    drv_en         = wr;
    write_n        = !wr;
    repeat (6) @(negedge clock);
    q              = hdata_in;
    chip_en_n      = 1'b1;
    dma_grant_n    = 1'b1;
    write_n        = 1'b1;
    read_direction = 1'b0;
    drv_en         = 1'b0;
    repeat (6) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ===== gtp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_host_port (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [7:0] hdata_in,
  output logic      [7:0] hdata_out,
  output logic            hdata_oe,
  input  wire logic       chip_en_n,
  input  wire logic       read_direction,
  input  wire logic       write_n,
  input  wire logic [2:0] reg_select,
  input  wire logic       dma_grant_n,
  output logic            dma_request_n,
  output logic            irq_out,
  output logic            irq_oe,
  input  wire logic       atn,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [14:0] s1_q;
  logic [14:0] s2_q;
  always_ff @(posedge clock) begin
    s1_q <= {hdata_in, chip_en_n, read_direction, write_n, reg_select, dma_grant_n};
    s2_q <= s1_q;
  end
  logic [7:0] d_s;
  logic       ce_n_s;
  logic       rdir_s;
  logic       we_n_s;
  logic [2:0] rs_s;
  logic       gr_n_s;
  assign {d_s, ce_n_s, rdir_s, we_n_s, rs_s, gr_n_s} = s2_q;

  // ************************************************
  // access decode
  // ************************************************
  logic       rd_act;
  logic       wr_act;
  logic [2:0] tgt;
  // normal read with direction high, dma read with it low
  assign rd_act = (!ce_n_s && rdir_s && gr_n_s) || (!gr_n_s && !rdir_s);
  assign wr_act = !we_n_s && ((!ce_n_s && gr_n_s) || (!gr_n_s && rdir_s));
  assign tgt    = gr_n_s ? rs_s : gtp_pkg::RS_DATA;

  logic       rd_q;
  logic       wr_q;
  logic [2:0] tgt_q;
  logic [7:0] wdat_q;
  logic       gr_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      tgt_q  <= 3'h0;
      wdat_q <= 8'h00;
      gr_q   <= 1'b0;
    end else begin
      rd_q  <= rd_act;
      wr_q  <= wr_act;
      gr_q  <= !gr_n_s;
      if (rd_act || wr_act) begin
        tgt_q <= tgt;
      end
      if (wr_act) begin
        wdat_q <= gtp_pkg::rev8(d_s);
      end
    end
  end
  // commit on strobe release so the data has settled
  logic wr_done;
  logic rd_done;
  logic gr_done;
  assign wr_done = wr_q && !wr_act;
  assign rd_done = rd_q && !rd_act;
  assign gr_done = gr_q && gr_n_s;

  // ************************************************
  // registers
  // ************************************************
  logic [7:0] cfg_q;
  logic [7:0] mask_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q  <= gtp_pkg::CFG_RST;
      mask_q <= gtp_pkg::MASK_RST;
    end else if (wr_done) begin
      if (tgt_q == gtp_pkg::RS_CFG) begin
        cfg_q <= wdat_q;
      end
      if (tgt_q == gtp_pkg::RS_STAT) begin
        mask_q <= wdat_q;
      end
    end
  end

  logic       b_in_ready;
  logic       b_out_valid;
  logic       b_pop;
  logic [7:0] b_out_data;
  gtp_buf2 #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_obuf (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (wr_done && (tgt_q == gtp_pkg::RS_DATA)),
    .in_ready  (b_in_ready),
    .in_data   (wdat_q),
    .out_valid (b_out_valid),
    .out_ready (b_pop),
    .out_data  (b_out_data)
  );

  // inbound byte register
  logic       in_full_q;
  logic [7:0] in_byte_q;
  logic       rd_data_done;
  assign rd_data_done = rd_done && (tgt_q == gtp_pkg::RS_DATA);
  always_ff @(posedge clock) begin
    if (srst) begin
      in_full_q <= 1'b0;
      rx_ready  <= 1'b0;
      in_byte_q <= 8'h00;
    end else begin
      if (rx_valid && rx_ready) begin
        in_full_q <= 1'b1;
        in_byte_q <= rx_data;
        rx_ready  <= 1'b0;
      end else if (rd_data_done) begin
        in_full_q <= 1'b0;
        rx_ready  <= 1'b1;
      end else begin
        rx_ready  <= !in_full_q;
      end
    end
  end

  // ************************************************
  // transmit settle and attention hold
  // ************************************************
  gtp_pkg::gtp_tx_e st_q;
  logic [4:0]       cnt_q;
  logic [4:0]       settle;
  logic             atn_held_q;
  always_comb begin
    case (cfg_q[gtp_pkg::CFG_SEL_LSB +: 2])
      2'h0:    settle = gtp_pkg::SETTLE_A;
      2'h1:    settle = gtp_pkg::SETTLE_B;
      2'h2:    settle = gtp_pkg::SETTLE_C;
      default: settle = gtp_pkg::SETTLE_D;
    endcase
  end
  // no pop under attention, so the byte stays at the head
  assign b_pop = (st_q == gtp_pkg::TX_VALID) && tx_ready && !atn;

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q       <= gtp_pkg::TX_IDLE;
      cnt_q      <= 5'h00;
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      atn_held_q <= 1'b0;
    end else begin
      case (st_q)
        gtp_pkg::TX_IDLE: begin
          if (b_out_valid && !atn) begin
            st_q  <= gtp_pkg::TX_SETTLE;
            cnt_q <= 5'h01;
          end
        end
        gtp_pkg::TX_SETTLE: begin
          if (atn) begin
            st_q <= gtp_pkg::TX_ATN;
          end else if (cnt_q >= settle) begin
            st_q     <= gtp_pkg::TX_VALID;
            tx_valid <= 1'b1;
            tx_data  <= b_out_data;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        gtp_pkg::TX_VALID: begin
          if (atn) begin
            st_q       <= gtp_pkg::TX_ATN;
            tx_valid   <= 1'b0;
            atn_held_q <= 1'b1;
          end else if (tx_ready) begin
            st_q     <= gtp_pkg::TX_IDLE;
            tx_valid <= 1'b0;
          end
        end
        gtp_pkg::TX_ATN: begin
          // byte stays at the buffer head, settle restarts
          if (!atn) begin
            st_q       <= gtp_pkg::TX_SETTLE;
            cnt_q      <= 5'h01;
            atn_held_q <= 1'b0;
          end
        end
        default: st_q <= gtp_pkg::TX_IDLE;
      endcase
    end
  end

  // ************************************************
  // read data, request, interrupt
  // ************************************************
  logic [7:0] stat;
  logic [7:0] rmux;
  assign stat = {5'h00, atn_held_q, b_in_ready, in_full_q};
  always_comb begin
    case (tgt)
      gtp_pkg::RS_STAT: rmux = stat;
      gtp_pkg::RS_CFG:  rmux = cfg_q;
      gtp_pkg::RS_DATA: rmux = in_byte_q;
      default:          rmux = 8'h00;
    endcase
  end

  logic dreq;
  assign dreq = (cfg_q[gtp_pkg::CFG_DMA_IN] && in_full_q)
             || (cfg_q[gtp_pkg::CFG_DMA_OUT] && b_in_ready);
  always_ff @(posedge clock) begin
    if (srst) begin
      hdata_out     <= 8'h00;
      hdata_oe      <= 1'b0;
      dma_request_n <= 1'b1;
      irq_oe        <= 1'b0;
      irq_out       <= 1'b0;
    end else begin
      hdata_oe  <= rd_act;
      hdata_out <= rd_act ? gtp_pkg::rev8(rmux) : 8'h00;
      // no request while a grant cycle is open or just closing
      dma_request_n <= !(dreq && gr_n_s && !gr_q && !gr_done);
      irq_oe  <= |(stat & mask_q);
      irq_out <= 1'b0;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_oe_follows: assert property (rd_act |=> hdata_oe ##0 $past(rd_act))
    else $error("data lines not driven during read");
  chk_oe_idle: assert property (!rd_act |=> !hdata_oe)
    else $error("data lines driven outside a read");
  chk_cfg_msb: assert property (rd_act && gr_n_s && rs_s == gtp_pkg::RS_CFG
      |=> hdata_out[0] == $past(cfg_q[7]) && hdata_out[7] == $past(cfg_q[0]))
    else $error("register bit order wrong on read");
  chk_dma_read: assert property (!gr_n_s && !rdir_s
      |=> hdata_oe && hdata_out == gtp_pkg::rev8($past(in_byte_q)))
    else $error("dma read not from inbound byte");
  chk_write_cfg: assert property (wr_done && tgt_q == gtp_pkg::RS_CFG
      |=> cfg_q == $past(wdat_q))
    else $error("write not latched");
  chk_irq_mask: assert property (##1 irq_oe == $past(|(stat & mask_q)) && !irq_out)
    else $error("interrupt output mismatch");
  chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
      srst |=> !hdata_oe && dma_request_n && !tx_valid && !irq_oe)
    else $error("not idle after reset");
  chk_settle_min: assert property ($rose(tx_valid) |-> $past(b_out_valid, 4))
    else $error("byte valid before settle delay");
  chk_atn_keep: assert property (tx_valid && atn |=> !tx_valid && b_out_valid
      && $stable(b_out_data))
    else $error("byte lost on attention");
  chk_req_drop: assert property (gr_done |=> dma_request_n)
    else $error("request not dropped after grant");

  cov_dma_read: cover property (!dma_request_n ##[1:20] gr_done);
  cov_tx_byte: cover property (tx_valid && tx_ready);
  cov_atn_hold: cover property (st_q == gtp_pkg::TX_ATN ##[1:20] tx_valid);
endmodule
`default_nettype wire

// ===== gtp_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gtp_host_port_tb;
  logic       clock, srst, atn, tx_ready, rx_valid;
  logic [7:0] rx_data, hdata_in, hdata_out, tx_data, q, rdv;
  logic       hdata_oe, chip_en_n, read_direction, write_n, dma_grant_n;
  logic       dma_request_n, irq_out, irq_oe, tx_valid, rx_ready;
  logic [2:0] reg_select;
  int         miscompares, compares, cnt;

  // ************************************************
  // instances
  // ************************************************
  gtp_host_port dut_u (.clock(clock), .srst(srst), .hdata_in(hdata_in),
    .hdata_out(hdata_out), .hdata_oe(hdata_oe), .chip_en_n(chip_en_n),
    .read_direction(read_direction), .write_n(write_n), .reg_select(reg_select),
    .dma_grant_n(dma_grant_n), .dma_request_n(dma_request_n), .irq_out(irq_out),
    .irq_oe(irq_oe), .atn(atn), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  gtp_host_model host_u (.clock(clock), .hdata_out(hdata_out), .hdata_oe(hdata_oe),
    .hdata_in(hdata_in), .chip_en_n(chip_en_n), .read_direction(read_direction),
    .write_n(write_n), .reg_select(reg_select), .dma_grant_n(dma_grant_n));

  always #50 clock = ~clock;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [7:0] rv(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [2:0] rs, input logic [7:0] v);
    host_u.acc(1'b0, 1'b0, 1'b1, rs, rv(v), q);
  endtask
  task automatic rd(input logic [2:0] rs);
    host_u.acc(1'b0, 1'b0, 1'b0, rs, 8'h00, q);
    rdv = rv(q);
  endtask
  // bounded wait; cnt is the cycles spent
  task automatic waitv();
    cnt = 0;
    while (tx_valid !== 1'b1 && cnt < 100) begin
      @(negedge clock);
      cnt++;
    end
    // a wait that runs out is a failure, not a silent pass
    chk(8'(tx_valid), 8'h01);
  endtask
  task automatic waitreq();
    cnt = 0;
    while (dma_request_n !== 1'b0 && cnt < 100) begin
      @(negedge clock);
      cnt++;
    end
    chk(8'(dma_request_n), 8'h00);
  endtask
  task automatic take();
    tx_ready = 1'b1;
    @(negedge clock);
    tx_ready = 1'b0;
  endtask
  task automatic do_reset();
    srst = 1'b1;
    repeat (10) @(negedge clock);
    srst = 1'b0;
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_select();
    chk({4'h0, hdata_oe, dma_request_n, irq_oe, tx_valid}, 8'h04);
    wr(gtp_pkg::RS_CFG, 8'h01);
    host_u.acc(1'b1, 1'b0, 1'b1, gtp_pkg::RS_CFG, rv(8'h02), q);
    host_u.acc(1'b1, 1'b0, 1'b0, gtp_pkg::RS_CFG, 8'h00, q);
    chk(q, 8'hFF);
    rd(gtp_pkg::RS_CFG);
    chk(rdv, 8'h01);
    do_reset();
    rd(gtp_pkg::RS_CFG);
    chk(rdv, 8'h00);
  endtask

  task automatic t_settle();
    int         d[4];
    logic [4:0] n[4];
    n = '{gtp_pkg::SETTLE_A, gtp_pkg::SETTLE_B, gtp_pkg::SETTLE_C, gtp_pkg::SETTLE_D};
    for (int s = 0; s < 4; s++) begin
      wr(gtp_pkg::RS_CFG, 8'(s));
      wr(gtp_pkg::RS_DATA, 8'hA0 + 8'(s));
      waitv();
      d[s] = cnt;
      chk(tx_data, 8'hA0 + 8'(s));
      take();
      chk(8'(d[s] - d[0]), 8'(n[s] - n[0]));
    end
    wr(gtp_pkg::RS_CFG, 8'h00);
  endtask

  // stalled consumer: fill until no space, one more is dropped
  task automatic t_full();
    int k;
    k = 0;
    do begin
      wr(gtp_pkg::RS_DATA, 8'h10 + 8'(k));
      k++;
      rd(gtp_pkg::RS_STAT);
    end while (rdv[gtp_pkg::ST_OUT_SPACE] && k < 4);
    chk(8'(k), 8'h02);
    wr(gtp_pkg::RS_DATA, 8'hEE);
    for (int i = 0; i < k; i++) begin
      waitv();
      repeat (3) @(negedge clock);
      chk(tx_data, 8'h10 + 8'(i));
      take();
    end
    repeat (40) @(negedge clock);
    chk(8'(tx_valid), 8'h00);
  endtask

  task automatic t_atn();
    wr(gtp_pkg::RS_DATA, 8'h77);
    waitv();
    atn = 1'b1;
    repeat (2) @(negedge clock);
    chk(8'(tx_valid), 8'h00);
    rd(gtp_pkg::RS_STAT);
    chk(8'(rdv[gtp_pkg::ST_ATN_HELD]), 8'h01);
    atn = 1'b0;
    waitv();
    chk(tx_data, 8'h77);
    take();
  endtask

  task automatic t_irq();
    wr(gtp_pkg::RS_STAT, 8'h01);
    chk({6'h0, irq_oe, irq_out}, 8'h00);
    wr(gtp_pkg::RS_STAT, 8'h02);
    chk({6'h0, irq_oe, irq_out}, 8'h02);
    wr(gtp_pkg::RS_STAT, 8'h00);
    chk({6'h0, irq_oe, irq_out}, 8'h00);
  endtask

  task automatic t_dma();
    wr(gtp_pkg::RS_CFG, 8'h04);
    chk(8'(rx_ready), 8'h01);
    rx_data  = 8'h5A;
    rx_valid = 1'b1;
    @(negedge clock);
    rx_valid = 1'b0;
    chk(8'(rx_ready), 8'h00);
    waitreq();
    chk(8'(dma_request_n), 8'h00);
    host_u.acc(1'b1, 1'b1, 1'b0, 3'h2, 8'h00, q);
    chk(rv(q), 8'h5A);
    chk(8'(dma_request_n), 8'h01);
    chk(8'(rx_ready), 8'h01);
    wr(gtp_pkg::RS_CFG, 8'h08);
    waitreq();
    chk(8'(dma_request_n), 8'h00);
    host_u.acc(1'b1, 1'b1, 1'b1, 3'h0, rv(8'h3C), q);
    waitv();
    chk(tx_data, 8'h3C);
    take();
    wr(gtp_pkg::RS_CFG, 8'h00);
  endtask

  // ************************************************
  // run control
  // ************************************************
  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    clock    = 1'b0;
    atn      = 1'b0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    do_reset();
    t_select();
    t_settle();
    t_full();
    t_atn();
    t_irq();
    t_dma();
    final_report();
  end

  // full run is about 500 cycles
  initial begin
    #2_000_000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

// ===== gtp_pkg.sv
// Function
// - bus bit zero carries register MSB
// - drive data lines only during reads
// - access only with chip select and strobe
// - dma inverts read direction sense
// - write strobe latches bus into register
// - grant forces data registers, ignores select
// - request asks dma controller for transfer
// - reset returns device to idle
// - interrupt low when unmasked condition true
// - interrupt pin only pulled low
// - programmable settle delay before byte valid
// - attention keeps byte being transmitted
`default_nettype none
package gtp_pkg;
  // ************************************************
  // clock and timing
  // ************************************************
  localparam int CLK_HZ     = 10_000_000;
  localparam int CLK_MAX_HZ = 20_000_000;
  localparam int T_A_NS     = 350;
  localparam int T_B_NS     = 500;
  localparam int T_C_NS     = 1100;
  localparam int T_D_NS     = 2000;

  // least time, rounded up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [4:0] SETTLE_A = 5'(ns2cyc(T_A_NS));
  localparam logic [4:0] SETTLE_B = 5'(ns2cyc(T_B_NS));
  localparam logic [4:0] SETTLE_C = 5'(ns2cyc(T_C_NS));
  localparam logic [4:0] SETTLE_D = 5'(ns2cyc(T_D_NS));

  // ************************************************
  // register map
  // ************************************************
  localparam logic [2:0] RS_STAT = 3'h0;
  localparam logic [2:0] RS_CFG  = 3'h2;
  localparam logic [2:0] RS_DATA = 3'h7;
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_DMA_IN   = 2;
  localparam int CFG_DMA_OUT  = 3;
  localparam int ST_IN_FULL   = 0;
  localparam int ST_OUT_SPACE = 1;
  localparam int ST_ATN_HELD  = 2;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef enum logic [1:0] {TX_IDLE, TX_SETTLE, TX_VALID, TX_ATN} gtp_tx_e;

  // internal bit 7 appears on host bit 0
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction
endpackage
`default_nettype wire
